// ==== lec_params.svh ====
// constants of the lookup engine control block
// Function
// - bit 7 set stops unicast source learning
// - self filter drops frames whose source matches
// - self drop needs port enable and global
// - bit 5 write starts whole-table flush, self-clears
// - flush option limits which entries flush
// - bit 4 write flushes spanning-tree entries
// - bit 3 clear drops multicast-source frames
// - bit 2 enables aging, resets to one
// - bit 1 selects fast aging, resets zero
// - bit 0 flushes ports whose link drops
// - double-tag trap sends reserved multicast host-only
// - dynamic hit map ANDed with VLAN map
// - static hit map ANDed with VLAN map
// - option 01 dynamic, 10 static, 11 both
// - aging time is period seconds times count
`ifndef LEC_PARAMS_SVH
`define LEC_PARAMS_SVH
`define LEC_NPORT        6
`define LEC_ADDR_CTRL1   16'h0311
`define LEC_ADDR_CTRL2   16'h0312
`define LEC_ADDR_AGEP    16'h0313
`define LEC_CTRL1_RST    8'h0c
`define LEC_CTRL2_RST    8'h00
`define LEC_AGEP_RST     8'h4b
`define LEC_RD_NONE      8'h00
`define LEC_C1_TRIG_MASK 8'h30
`define LEC_B_LRN_DIS    7
`define LEC_B_SELF       6
`define LEC_B_FL_ALL     5
`define LEC_B_FL_MSTP    4
`define LEC_B_MCSA_FWD   3
`define LEC_B_AGE_EN     2
`define LEC_B_FAST       1
`define LEC_B_LD_FLUSH   0
`define LEC_B_DT_TRAP    6
`define LEC_B_DYN_VF     5
`define LEC_B_STA_VF     4
`define LEC_B_FOPT_HI    3
`define LEC_B_FOPT_LO    2
`define LEC_FOPT_NONE    2'h0
`define LEC_FOPT_DYN     2'h1
`define LEC_FOPT_STA     2'h2
`define LEC_FOPT_BOTH    2'h3
`define LEC_SA_MC_BIT    40
`define LEC_HOST_MAP     6'h20
`define LEC_CLK_NS       4
`define LEC_SEC_NS       1000000000
`define LEC_FAST_NS      1000000
`endif

// ==== lec_pkg.sv ====
// types shared by the lookup engine control block
`include "lec_params.svh"
package lec_pkg;
  typedef logic [`LEC_NPORT-1:0] lec_map_t;
  typedef enum logic {
    LEC_ST_IDLE = 1'b0,
    LEC_ST_RUN  = 1'b1
  } lec_state_e;
  typedef enum logic [1:0] {
    LEC_FK_ALL  = 2'h0,
    LEC_FK_MSTP = 2'h1,
    LEC_FK_PORT = 2'h2
  } lec_flush_kind_e;
  typedef struct packed {
    logic        valid;
    logic [2:0]  src_port;
    logic [47:0] sa;
    logic        rsvd_mc;
    logic        dbl_tag;
    logic        hit;
    logic        hit_static;
    lec_map_t    entry_map;
    lec_map_t    vlan_map;
  } lec_frame_s;
  typedef struct packed {
    logic     valid;
    logic     drop;
    logic     learn;
    logic     trap;
    lec_map_t fwd_map;
  } lec_verdict_s;
  typedef struct packed {
    logic            valid;
    lec_flush_kind_e kind;
    logic            dyn;
    logic            stat;
    lec_map_t        port_mask;
  } lec_flush_cmd_s;
endpackage

// ==== lec_aging.sv ====
// aging timebase: one tick per age period
`timescale 1ns/1ps
`include "lec_params.svh"
module lec_aging #(
  parameter int unsigned SEC_CYCLES  = `LEC_SEC_NS / `LEC_CLK_NS,
  parameter int unsigned FAST_CYCLES = `LEC_FAST_NS / `LEC_CLK_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       age_en,
  input  wire logic       fast,
  input  wire logic [7:0] period,
  output logic            age_tick
);
  logic [31:0] unit_cnt_reg;
  logic [31:0] unit_cnt_next;
  logic [7:0]  per_cnt_reg;
  logic [7:0]  per_cnt_next;
  logic        tick_reg;
  logic [31:0] unit_len;
  logic        unit_end;
  logic        per_end;

  // fast mode only shortens the unit, the period count is kept
  assign unit_len = fast ? FAST_CYCLES : SEC_CYCLES;
  assign unit_end = (unit_cnt_reg >= unit_len - 32'h1);
  assign per_end  = unit_end && (per_cnt_reg + 8'h1 >= period);
  assign unit_cnt_next = unit_end ? 32'h0 : unit_cnt_reg + 32'h1;
  assign per_cnt_next  = per_end ? 8'h0
                       : (unit_end ? per_cnt_reg + 8'h1 : per_cnt_reg);
  assign age_tick = tick_reg;

  // disabled or zero period: counters cleared, no tick at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_reg <= 32'h0;
      per_cnt_reg  <= 8'h0;
      tick_reg     <= 1'b0;
    end else if (!age_en || period == 8'h0) begin
      unit_cnt_reg <= 32'h0;
      per_cnt_reg  <= 8'h0;
      tick_reg     <= 1'b0;
    end else begin
      unit_cnt_reg <= unit_cnt_next;
      per_cnt_reg  <= per_cnt_next;
      tick_reg     <= per_end;
    end
  end
endmodule

// ==== lec_verdict.sv ====
// per-frame filter, learn and egress map decision
`timescale 1ns/1ps
`include "lec_params.svh"
module lec_verdict (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            ctrl1,
  input  wire logic [7:0]            ctrl2,
  input  wire logic [47:0]           self_mac,
  input  wire lec_pkg::lec_map_t     port_self_en,
  input  wire lec_pkg::lec_frame_s   frame,
  output lec_pkg::lec_verdict_s      verdict
);
  lec_pkg::lec_verdict_s verdict_reg;
  lec_pkg::lec_verdict_s verdict_next;
  lec_pkg::lec_map_t     hit_map;
  logic                  port_en;
  logic                  mc_sa;
  logic                  drop_self;
  logic                  drop_mc;
  logic                  drop;
  logic                  trap;

  // entry map, optionally narrowed by the vlan member map
  function automatic lec_pkg::lec_map_t vmask(
    input lec_pkg::lec_map_t entry,
    input lec_pkg::lec_map_t vlan,
    input logic              en
  );
    vmask = en ? (entry & vlan) : entry;
  endfunction

  // out-of-range source ports never self-filter
  assign port_en = (frame.src_port < 3'(`LEC_NPORT))
                 && port_self_en[frame.src_port];
  assign mc_sa     = frame.sa[`LEC_SA_MC_BIT];
  assign drop_self = ctrl1[`LEC_B_SELF] && port_en
                  && (frame.sa == self_mac);
  assign drop_mc   = mc_sa && !ctrl1[`LEC_B_MCSA_FWD];
  assign drop      = drop_self || drop_mc;
  assign trap      = ctrl2[`LEC_B_DT_TRAP] && frame.dbl_tag
                  && frame.rsvd_mc;
  assign hit_map = frame.hit_static
    ? vmask(frame.entry_map, frame.vlan_map, ctrl2[`LEC_B_STA_VF])
    : vmask(frame.entry_map, frame.vlan_map, ctrl2[`LEC_B_DYN_VF]);

  // dropped frames carry an empty map; trap beats the lookup
  always_comb begin
    verdict_next.valid = frame.valid;
    verdict_next.drop  = frame.valid && drop;
    verdict_next.trap  = frame.valid && !drop && trap;
    verdict_next.learn = frame.valid && !drop && !mc_sa
                      && !ctrl1[`LEC_B_LRN_DIS];
    if (!frame.valid || drop) begin
      verdict_next.fwd_map = '0;
    end else if (trap) begin
      verdict_next.fwd_map = `LEC_HOST_MAP;
    end else if (frame.hit) begin
      verdict_next.fwd_map = hit_map;
    end else begin
      verdict_next.fwd_map = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      verdict_reg <= '0;
    end else begin
      verdict_reg <= verdict_next;
    end
  end

  assign verdict = verdict_reg;
endmodule

// ==== lec_top.sv ====
// lookup engine control: registers, flush sequencer, aging, verdicts
`timescale 1ns/1ps
`include "lec_params.svh"
module lec_top #(
  parameter int unsigned SEC_CYCLES  = `LEC_SEC_NS / `LEC_CLK_NS,
  parameter int unsigned FAST_CYCLES = `LEC_FAST_NS / `LEC_CLK_NS
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [15:0]             bus_addr,
  input  wire logic [7:0]              bus_wdata,
  input  wire logic                    bus_wr,
  input  wire logic                    bus_rd,
  output logic [7:0]                   bus_rdata,
  input  wire logic [47:0]             self_mac,
  input  wire lec_pkg::lec_map_t       port_self_en,
  input  wire lec_pkg::lec_map_t       link_up,
  input  wire lec_pkg::lec_frame_s     frame,
  output lec_pkg::lec_verdict_s        verdict,
  output lec_pkg::lec_flush_cmd_s      flush_cmd,
  input  wire logic                    flush_done,
  output logic                         age_tick
);
  ////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]               ctrl1_reg;
  logic [7:0]               ctrl1_next;
  logic [7:0]               ctrl2_reg;
  logic [7:0]               agep_reg;
  logic [7:0]               rdata_reg;
  logic [7:0]               rdata_next;
  logic [7:0]               ctrl1_view;
  logic                     wr_c1;
  logic                     wr_c2;
  logic                     wr_ag;
  logic [1:0]               fopt;
  logic                     fopt_on;
  logic                     start_all;
  logic                     start_mstp;
  lec_pkg::lec_map_t        link_prev_reg;
  lec_pkg::lec_map_t        ld_evt;
  logic                     pend_all_reg;
  logic                     pend_all_next;
  logic                     pend_mstp_reg;
  logic                     pend_mstp_next;
  lec_pkg::lec_map_t        pend_port_reg;
  lec_pkg::lec_map_t        pend_port_next;
  lec_pkg::lec_map_t        port_pick;
  lec_pkg::lec_map_t        clr_port;
  lec_pkg::lec_state_e      state_reg;
  lec_pkg::lec_state_e      state_next;
  lec_pkg::lec_flush_cmd_s  cmd_reg;
  lec_pkg::lec_flush_cmd_s  cmd_next;
  logic                     done_now;
  logic                     any_pend;
  logic                     done_all;
  logic                     done_mstp;

  ////////////////////////////////////////////////////////////////////
  // register bus decode
  assign wr_c1 = bus_wr && (bus_addr == `LEC_ADDR_CTRL1);
  assign wr_c2 = bus_wr && (bus_addr == `LEC_ADDR_CTRL2);
  assign wr_ag = bus_wr && (bus_addr == `LEC_ADDR_AGEP);

  // trigger bits are never stored; their read-back is the busy state
  assign ctrl1_next = bus_wdata & ~`LEC_C1_TRIG_MASK;

  // trigger positions show the pending flushes
  always_comb begin
    ctrl1_view = ctrl1_reg;
    ctrl1_view[`LEC_B_FL_ALL]  = pend_all_reg;
    ctrl1_view[`LEC_B_FL_MSTP] = pend_mstp_reg;
  end

  // read mux, unmapped offsets read as zero
  always_comb begin
    rdata_next = `LEC_RD_NONE;
    if (bus_rd) begin
      unique case (bus_addr)
        `LEC_ADDR_CTRL1: rdata_next = ctrl1_view;
        `LEC_ADDR_CTRL2: rdata_next = ctrl2_reg;
        `LEC_ADDR_AGEP:  rdata_next = agep_reg;
        default:         rdata_next = `LEC_RD_NONE;
      endcase
    end
  end

  // configuration storage with documented reset values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg <= `LEC_CTRL1_RST;
      ctrl2_reg <= `LEC_CTRL2_RST;
      agep_reg  <= `LEC_AGEP_RST;
    end else begin
      if (wr_c1) begin
        ctrl1_reg <= ctrl1_next;
      end
      if (wr_c2) begin
        ctrl2_reg <= bus_wdata;
      end
      if (wr_ag) begin
        agep_reg <= bus_wdata;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `LEC_RD_NONE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////
  // flush requests
  assign fopt    = ctrl2_reg[`LEC_B_FOPT_HI:`LEC_B_FOPT_LO];
  // option 00 means nothing to flush: the trigger just falls back
  assign fopt_on = (fopt != `LEC_FOPT_NONE);
  assign start_all  = wr_c1 && bus_wdata[`LEC_B_FL_ALL]
                   && fopt_on;
  assign start_mstp = wr_c1 && bus_wdata[`LEC_B_FL_MSTP]
                   && fopt_on;

  // falling edge of a port's link, gated by the enable
  assign ld_evt = link_prev_reg & ~link_up
                & {`LEC_NPORT{ctrl1_reg[`LEC_B_LD_FLUSH]}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_prev_reg <= '0;
    end else begin
      link_prev_reg <= link_up;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pending flags: a new request wins over the clear on completion
  assign done_now  = (state_reg == lec_pkg::LEC_ST_RUN) && flush_done;
  assign done_all  = done_now && (cmd_reg.kind == lec_pkg::LEC_FK_ALL);
  assign done_mstp = done_now && (cmd_reg.kind == lec_pkg::LEC_FK_MSTP);
  assign clr_port  = (done_now && cmd_reg.kind == lec_pkg::LEC_FK_PORT)
                   ? cmd_reg.port_mask : '0;

  assign pend_all_next  = (pend_all_reg && !done_all) || start_all;
  assign pend_mstp_next = (pend_mstp_reg && !done_mstp)
                       || start_mstp;
  assign pend_port_next = (pend_port_reg & ~clr_port) | ld_evt;
  assign any_pend = pend_all_reg || pend_mstp_reg || (|pend_port_reg);

  // lowest pending port first; one port per command
  assign port_pick = pend_port_reg & (~pend_port_reg + 6'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_all_reg  <= 1'b0;
      pend_mstp_reg <= 1'b0;
      pend_port_reg <= '0;
    end else begin
      pend_all_reg  <= pend_all_next;
      pend_mstp_reg <= pend_mstp_next;
      pend_port_reg <= pend_port_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flush sequencer: issue one command and hold it until done
  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    unique case (state_reg)
      lec_pkg::LEC_ST_IDLE: begin
        cmd_next = '0;
        if (any_pend) begin
          state_next      = lec_pkg::LEC_ST_RUN;
          cmd_next.valid  = 1'b1;
          // scope is sampled at issue, later option writes wait
          cmd_next.dyn    = fopt[0];
          cmd_next.stat   = fopt[1];
          if (pend_all_reg) begin
            cmd_next.kind = lec_pkg::LEC_FK_ALL;
          end else if (pend_mstp_reg) begin
            cmd_next.kind = lec_pkg::LEC_FK_MSTP;
          end else begin
            // link loss clears learned entries only
            cmd_next.kind      = lec_pkg::LEC_FK_PORT;
            cmd_next.dyn       = 1'b1;
            cmd_next.stat      = 1'b0;
            cmd_next.port_mask = port_pick;
          end
        end
      end
      lec_pkg::LEC_ST_RUN: begin
        if (flush_done) begin
          state_next = lec_pkg::LEC_ST_IDLE;
          cmd_next   = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= lec_pkg::LEC_ST_IDLE;
      cmd_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
    end
  end

  assign flush_cmd = cmd_reg;

  ////////////////////////////////////////////////////////////////////
  // aging timebase
  lec_aging #(
    .SEC_CYCLES  (SEC_CYCLES),
    .FAST_CYCLES (FAST_CYCLES)
  ) u_aging (
    .clk      (clk),
    .rst_n    (rst_n),
    .age_en   (ctrl1_reg[`LEC_B_AGE_EN]),
    .fast     (ctrl1_reg[`LEC_B_FAST]),
    .period   (agep_reg),
    .age_tick (age_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // frame verdicts
  lec_verdict u_verdict (
    .clk          (clk),
    .rst_n        (rst_n),
    .ctrl1        (ctrl1_reg),
    .ctrl2        (ctrl2_reg),
    .self_mac     (self_mac),
    .port_self_en (port_self_en),
    .frame        (frame),
    .verdict      (verdict)
  );
endmodule

// ==== lec_top_monitor.sv ====
// port checker for the lookup engine control top
`timescale 1ns/1ps
`include "lec_params.svh"
module lec_top_monitor (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [15:0]             bus_addr,
  input wire logic [7:0]              bus_wdata,
  input wire logic                    bus_wr,
  input wire logic                    bus_rd,
  input wire logic [7:0]              bus_rdata,
  input wire logic [47:0]             self_mac,
  input wire lec_pkg::lec_map_t       port_self_en,
  input wire lec_pkg::lec_map_t       link_up,
  input wire lec_pkg::lec_frame_s     frame,
  input wire lec_pkg::lec_verdict_s   verdict,
  input wire lec_pkg::lec_flush_cmd_s flush_cmd,
  input wire logic                    flush_done,
  input wire logic                    age_tick
);
  logic [7:0] c1_reg;
  logic [7:0] c2_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // shadow of control bytes; trigger bits unused, so no self-clear model
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_reg <= `LEC_CTRL1_RST;
      c2_reg <= `LEC_CTRL2_RST;
    end else if (bus_wr) begin
      if (bus_addr == `LEC_ADDR_CTRL1) c1_reg <= bus_wdata;
      if (bus_addr == `LEC_ADDR_CTRL2) c2_reg <= bus_wdata;
    end
  end
  // frame-side decodes and the flush option field
  wire       trap_c = c2_reg[6] & frame.dbl_tag & frame.rsvd_mc;
  wire       vf_on  = frame.hit_static ? c2_reg[4] : c2_reg[5];
  wire [1:0] fopt   = c2_reg[3:2];
  wire [5:0] emap   = frame.entry_map & (vf_on ? frame.vlan_map : 6'h3f);
  wire       self_c = c1_reg[6] && frame.src_port < 3'h6 &&
                      port_self_en[frame.src_port] && frame.sa == self_mac;
  ////////////////////////////////////////////////////////////////////////
  property p_learn;
    frame.valid && c1_reg[7] |=> !verdict.learn;
  endproperty
  a_learn: assert property (p_learn) else $error("unicast learned");
  property p_self;
    frame.valid && self_c |=> verdict.drop;
  endproperty
  a_self: assert property (p_self) else $error("self frame kept");
  property p_noself;
    frame.valid && !c1_reg[6] && !frame.sa[40] |=> !verdict.drop;
  endproperty
  a_noself: assert property (p_noself) else $error("bad drop");
  // global on but the port's own enable off: still no self drop
  property p_noport;
    frame.valid && frame.src_port < 3'h6 && !frame.sa[40] &&
      !port_self_en[frame.src_port] |=> !verdict.drop;
  endproperty
  a_noport: assert property (p_noport) else $error("port drop");
  property p_mcsa;
    frame.valid && frame.sa[40] && !c1_reg[3] |=> verdict.drop;
  endproperty
  a_mcsa: assert property (p_mcsa) else $error("mc source kept");
  property p_trap;
    frame.valid && trap_c |=> verdict.drop ||
      (verdict.trap && verdict.fwd_map == `LEC_HOST_MAP);
  endproperty
  a_trap: assert property (p_trap) else $error("trap map");
  property p_vf;
    frame.valid && frame.hit && !trap_c |=>
      verdict.drop || verdict.fwd_map == $past(emap);
  endproperty
  a_vf: assert property (p_vf) else $error("egress map");
  property p_rd0;
    !bus_rd |=> bus_rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  property p_hold;
    flush_cmd.valid && !flush_done |=> $stable(flush_cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("flush cmd moved");
  property p_fopt;
    $rose(flush_cmd.valid) && flush_cmd.kind != lec_pkg::LEC_FK_PORT
      |-> {flush_cmd.stat, flush_cmd.dyn} == $past(fopt);
  endproperty
  a_fopt: assert property (p_fopt) else $error("flush scope");
  property p_port;
    flush_cmd.valid && flush_cmd.kind == lec_pkg::LEC_FK_PORT |->
      flush_cmd.dyn && !flush_cmd.stat && $onehot(flush_cmd.port_mask);
  endproperty
  a_port: assert property (p_port) else $error("port flush");
  // two cycles off so a tick launched before the write is excused
  property p_age;
    !c1_reg[2] ##1 !c1_reg[2] |-> !age_tick;
  endproperty
  a_age: assert property (p_age) else $error("tick while off");
  c_trap: cover property (frame.valid && trap_c);
  c_flush: cover property ($rose(flush_cmd.valid));
  c_age: cover property (age_tick);
endmodule
bind lec_top lec_top_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .self_mac(self_mac),
  .port_self_en(port_self_en), .link_up(link_up), .frame(frame),
  .verdict(verdict), .flush_cmd(flush_cmd), .flush_done(flush_done),
  .age_tick(age_tick));

// ==== tb_lookup_engine_control.sv ====
// self-checking bench for the lookup engine control block
`timescale 1ns/1ps
`include "lec_params.svh"
module tb_lookup_engine_control;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [15:0]             bus_addr = 16'h0000;
  logic [7:0]              bus_wdata = 8'h00;
  logic                    bus_wr = 1'b0;
  logic                    bus_rd = 1'b0;
  logic [7:0]              bus_rdata;
  logic [47:0]             self_mac = 48'h5a3c961e7702;
  lec_pkg::lec_map_t       port_self_en = 6'h00;
  lec_pkg::lec_map_t       link_up = 6'h3f;
  lec_pkg::lec_frame_s     frame = '0;
  lec_pkg::lec_verdict_s   verdict;
  lec_pkg::lec_verdict_s   exp_v;
  lec_pkg::lec_flush_cmd_s flush_cmd;
  logic                    flush_done = 1'b0;
  logic                    age_tick;
  logic [7:0]              m1 = `LEC_CTRL1_RST;
  logic [7:0]              m2 = `LEC_CTRL2_RST;
  int                      errors = 0;
  int                      tests_run = 0;
  int                      seed = 32'h8362;
  int                      c;
  always #2 clk = ~clk;
  // short age units keep the aging runs brief
  lec_top #(.SEC_CYCLES(8), .FAST_CYCLES(2)) dut (.clk(clk),
    .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .self_mac(self_mac), .port_self_en(port_self_en), .link_up(link_up),
    .frame(frame), .verdict(verdict), .flush_cmd(flush_cmd),
    .flush_done(flush_done), .age_tick(age_tick));
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // model keeps a pending trigger only when a flush scope is chosen
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    if (a == `LEC_ADDR_CTRL2) m2 = d;
    if (a == `LEC_ADDR_CTRL1)
      m1 = {d[7:6], m1[5:4] | (d[5:4] & {2{m2[3:2] != 2'h0}}), d[3:0]};
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    chk(bus_rdata, e);
  endtask
  // waits for a command, holds the table busy, then completes it
  task automatic flush(input logic [1:0] k, input logic [5:0] mk,
                       input logic [1:0] ds);
    lec_pkg::lec_flush_cmd_s s;
    c = 0;
    while (flush_cmd.valid !== 1'b1 && c < 50) begin
      @(negedge clk);
      c++;
    end
    if (c >= 50) begin
      errors++;
      report_and_stop();
    end
    s = flush_cmd;
    chk({s.kind, s.stat, s.dyn}, {k, ds});
    if (k == 2'h2) chk(s.port_mask, mk);
    repeat (3) begin
      @(negedge clk);
      chk(flush_cmd, s);
    end
    @(posedge clk) flush_done <= 1'b1;
    @(posedge clk) flush_done <= 1'b0;
    @(negedge clk);
    chk(flush_cmd.valid, 1'b0);
  endtask
  // counts cycles up to the next aging tick
  task automatic tick();
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (age_tick !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      errors++;
      report_and_stop();
    end
  endtask
  function automatic lec_pkg::lec_verdict_s vmodel(lec_pkg::lec_frame_s f);
    lec_pkg::lec_verdict_s v;
    logic sd;
    v = '0;
    sd = m1[6] && f.src_port < 3'h6 && port_self_en[f.src_port] &&
         f.sa == self_mac;
    v.valid = f.valid;
    v.drop = f.valid && (sd || (f.sa[40] && !m1[3]));
    v.learn = f.valid && !v.drop && !f.sa[40] && !m1[7];
    v.trap = f.valid && !v.drop && m2[6] && f.dbl_tag && f.rsvd_mc;
    if (v.trap) v.fwd_map = `LEC_HOST_MAP;
    else if (f.valid && !v.drop && f.hit)
      v.fwd_map = f.entry_map &
        ((f.hit_static ? m2[4] : m2[5]) ? f.vlan_map : 6'h3f);
    return v;
  endfunction
  // half the frames carry the own address to exercise self filtering
  function automatic lec_pkg::lec_frame_s rnd_frame();
    lec_pkg::lec_frame_s f;
    f = 68'({$random(seed), $random(seed), $random(seed)});
    if (f.rsvd_mc ^ f.hit_static) f.sa = self_mac;
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // verdict model runs beside the design and is compared every cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) exp_v <= '0;
    else exp_v <= vmodel(frame);
  end
  always @(negedge clk) begin
    if (rst_n) chk(verdict, exp_v);
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      wr(`LEC_ADDR_CTRL1, 8'($random(seed)) & 8'hce);
      wr(`LEC_ADDR_CTRL2, 8'($random(seed)) & 8'hf3);
      port_self_en <= 6'($random(seed));
      repeat (30) @(posedge clk) frame <= rnd_frame();
      @(posedge clk) frame <= '0;
    end
    // mid-run reset must bring back the defaults
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    m1 = `LEC_CTRL1_RST;
    m2 = `LEC_CTRL2_RST;
    rd(`LEC_ADDR_CTRL1, 8'h0c);
    rd(`LEC_ADDR_CTRL2, 8'h00);
    rd(`LEC_ADDR_AGEP, 8'h4b);
    wr(16'h0314, 8'hff);
    rd(16'h0314, 8'h00);
    for (int t = 0; t < 2; t++) begin
      for (int o = 0; o < 4; o++) begin
        wr(`LEC_ADDR_CTRL2, {4'h0, o[1:0], 2'h0});
        wr(`LEC_ADDR_CTRL1, t ? 8'h1c : 8'h2c);
        rd(`LEC_ADDR_CTRL1, m1);
        if (o != 0) flush(t[1:0], 6'h00, o[1:0]);
        else chk(flush_cmd.valid, 1'b0);
        m1[5 - t] = 1'b0;
        rd(`LEC_ADDR_CTRL1, m1);
      end
    end
    wr(`LEC_ADDR_CTRL1, 8'h3c);
    flush(2'h0, 6'h00, 2'h3);
    flush(2'h1, 6'h00, 2'h3);
    m1 = 8'h0c;
    wr(`LEC_ADDR_CTRL1, 8'h0d);
    @(posedge clk) link_up <= 6'h3b;
    flush(2'h2, 6'h04, 2'h1);
    wr(`LEC_ADDR_CTRL1, 8'h08);
    @(posedge clk) link_up <= 6'h33;
    repeat (20) @(negedge clk) chk(flush_cmd.valid, 1'b0);
    wr(`LEC_ADDR_AGEP, 8'h03);
    rd(`LEC_ADDR_AGEP, 8'h03);
    wr(`LEC_ADDR_CTRL1, 8'h0c);
    tick();
    tick();
    chk(c, 24);
    wr(`LEC_ADDR_CTRL1, 8'h08);
    wr(`LEC_ADDR_CTRL1, 8'h0e);
    tick();
    tick();
    chk(c, 6);
    wr(`LEC_ADDR_CTRL1, 8'h08);
    repeat (2) @(posedge clk);
    repeat (60) @(negedge clk) chk(age_tick, 1'b0);
    report_and_stop();
  end
endmodule
